// ===== hdl/ebt_top.sv
// Break and bus trace unit of the emulator, target clock domain
`timescale 1ns/1ps
module ebt_top (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic i_force_break,
  input wire logic i_bus_valid,
  input wire logic [31:0] i_bus_addr,
  input wire logic [31:0] i_bus_data,
  input wire logic i_bus_rw,
  input wire logic [7:0] i_bus_asid,
  input wire logic [1:0] i_bus_type,
  input wire logic [3:0] i_bus_probe,
  input wire logic [10:0] i_bus_ctrl,
  input wire logic [7:0] i_bus_clks,
  input wire logic i_pc_valid,
  input wire logic [31:0] i_pc,
  input wire logic i_exec_done,
  input wire logic i_c1_en,
  input wire ebt_pkg::ebt_sel_e i_c1_sel,
  input wire logic [31:0] i_c1_value,
  input wire logic i_c1_pre,
  input wire logic [ebt_pkg::C1_CNT_W-1:0] i_c1_count,
  input wire logic i_c2_en,
  input wire ebt_pkg::ebt_sel_e i_c2_sel,
  input wire logic [31:0] i_c2_value,
  input wire logic i_c2_pre,
  input wire logic i_bc_en,
  input wire logic [31:0] i_bc_addr,
  input wire logic [ebt_pkg::BC_CNT_W-1:0] i_bc_count,
  input wire logic [ebt_pkg::BC_CNT_W-1:0] i_bc_delay,
  input wire logic i_seq_mode,
  input wire logic i_sb_wr,
  input wire logic [ebt_pkg::SB_IDX_W-1:0] i_sb_idx,
  input wire logic i_sb_valid,
  input wire logic [31:0] i_sb_addr,
  input wire logic [ebt_pkg::SB_PASS_W-1:0] i_sb_pass,
  input wire logic i_pp_wr,
  input wire logic [ebt_pkg::PP_IDX_W-1:0] i_pp_idx,
  input wire logic [31:0] i_pp_addr,
  input wire logic [ebt_pkg::PP_IDX_W-1:0] i_pp_num,
  input wire logic i_rp_en,
  input wire logic [31:0] i_rp_addr,
  input wire logic i_swbrk_hit,
  input wire logic [ebt_pkg::SB_IDX_W-1:0] i_swbrk_idx,
  input wire logic [ebt_pkg::TR_AW-1:0] i_tr_rd_idx,
  input wire logic i_bt_clk,
  input wire logic i_bt_frame,
  input wire logic [ebt_pkg::BT_NIB_W-1:0] i_bt_data,
  input wire logic i_por_n,
  output logic o_running,
  output logic o_halt_req,
  output logic o_step,
  output logic o_err,
  output logic [7:0] o_err_code,
  output logic o_sw_req,
  output logic o_sw_restore,
  output logic [31:0] o_sw_addr,
  output logic o_c2_lost,
  output logic [ebt_pkg::TR_REC_W-1:0] o_tr_rd_data,
  output logic [ebt_pkg::TR_AW-1:0] o_tr_count,
  output logic o_bt_stb,
  output logic [31:0] o_bt_addr,
  output logic o_bt_partial
);
  import ebt_pkg::*;

  // Comparator decode shared by both channels, bus fields or PC
  function automatic logic chan_hit(input ebt_sel_e sel, input logic [31:0] v,
      input logic [31:0] a, input logic [31:0] d, input logic rw,
      input logic [7:0] asid, input logic [1:0] ty, input logic bv,
      input logic [31:0] pc, input logic pv);
    chan_hit = 1'b0;
    case (sel)
      EBT_SEL_ADDR: chan_hit = bv && a == v;
      EBT_SEL_DATA: chan_hit = bv && d == v;
      EBT_SEL_PC: chan_hit = pv && pc == v;
      EBT_SEL_ASID: chan_hit = bv && asid == v[7:0];
      EBT_SEL_RW: chan_hit = bv && rw == v[0];
      EBT_SEL_TYPE: chan_hit = bv && ty == v[1:0];
      default: chan_hit = 1'b0;
    endcase
  endfunction : chan_hit

  // Address merge mask from the number of nibbles in a transfer
  function automatic logic [31:0] bt_mask(input logic [3:0] n);
    case (n)
      4'h8: bt_mask = 32'hffffffff;
      4'h4: bt_mask = 32'h0000ffff;
      4'h2: bt_mask = 32'h000000ff;
      4'h1: bt_mask = 32'h0000000f;
      default: bt_mask = 32'h00000000;
    endcase
  endfunction : bt_mask

  ebt_state_e st_ff; // Run sequencer
  ebt_state_e nxt_st;
  logic run_d_ff; // Previous run request, for edge finding
  logic running_ff; // Run state, registered so the output leaves a flop
  logic halt_ff; // Combined halt request
  logic err_ff;
  logic [7:0] err_code_ff;
  logic [SB_IDX_W-1:0] walk_ff; // Breakpoint table walk index
  logic sw_req_ff;
  logic sw_restore_ff;
  logic [31:0] sw_addr_ff;
  logic step_ff; // Single-step request for pass handling
  logic c2_lost_ff; // Second channel taken by stepping
  logic [C1_CNT_W-1:0] c1_cnt_ff;
  logic c1_pend_ff; // Post-execution break waiting
  logic c2_pend_ff;
  logic seq_armed_ff; // Second channel seen in sequence mode
  logic [BC_CNT_W-1:0] bc_cnt_ff;
  logic bc_dly_ff; // Delay phase of bus channel
  logic [BC_CNT_W-1:0] bc_dcnt_ff;
  logic [PP_IDX_W-1:0] pp_stage_ff; // Next expected pass point
  logic [SB_NUM-1:0] sb_vld_ff; // Breakpoint slot in use
  logic [31:0] sb_addr_mem [SB_NUM];
  logic [SB_PASS_W-1:0] sb_pass_mem [SB_NUM];
  logic [SB_PASS_W-1:0] sb_cnt_mem [SB_NUM];
  logic [31:0] pp_mem [PP_NUM];
  logic [TR_REC_W-1:0] tr_mem [TR_DEPTH]; // Trace store
  logic [TR_AW-1:0] tr_wp_ff;
  logic [TR_AW-1:0] tr_cnt_ff;
  logic [TR_REC_W-1:0] tr_rd_ff;
  logic [31:0] ts_ff; // Free-running time stamp
  logic por_blk_ff; // Trace blocked after target power-on reset
  logic por_d_ff;
  logic [5:0] bt_s; // Synchronised clock, frame and nibble
  logic bt_clk_d_ff;
  logic bt_frm_d_ff;
  logic [31:0] bt_acc_ff;
  logic [3:0] bt_nib_ff;
  logic [31:0] bt_ref_ff; // Last full reference address
  logic bt_ref_ok_ff;
  logic bt_stb_ff;
  logic [31:0] bt_addr_ff;
  logic bt_part_ff;
  logic por_s;

  // Link signals and the reset pin come from outside this clock
  ebt_sync #(.W(6)) u_bt_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d({i_bt_clk, i_bt_frame, i_bt_data}),
    .o_q(bt_s)
  );
  ebt_sync #(.W(1)) u_por_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d(i_por_n),
    .o_q(por_s)
  );

  // Decode of run control and break sources
  wire in_run = st_ff == EBT_ST_RUN;
  wire run_rise = i_run && !run_d_ff;
  wire seq_bad = i_seq_mode && !(i_c1_en && i_c2_en);
  wire c2_on = i_c2_en && !c2_lost_ff;
  wire c1_raw = i_c1_en && in_run && chan_hit(i_c1_sel, i_c1_value, i_bus_addr,
      i_bus_data, i_bus_rw, i_bus_asid, i_bus_type, i_bus_valid, i_pc, i_pc_valid);
  wire c2_raw = c2_on && in_run && chan_hit(i_c2_sel, i_c2_value, i_bus_addr,
      i_bus_data, i_bus_rw, i_bus_asid, i_bus_type, i_bus_valid, i_pc, i_pc_valid);
  // Count of zero acts as one
  wire [C1_CNT_W-1:0] c1_need = (i_c1_count == '0) ? 12'h001 : i_c1_count;
  wire c1_fire = c1_raw && (c1_cnt_ff == c1_need - 12'h001);
  wire c1_post = c1_fire && i_c1_sel == EBT_SEL_PC && !i_c1_pre;
  wire c2_post = c2_raw && i_c2_sel == EBT_SEL_PC && !i_c2_pre;
  wire c1_evt = (c1_fire && !c1_post) || (c1_pend_ff && i_exec_done);
  wire c2_evt = (c2_raw && !c2_post) || (c2_pend_ff && i_exec_done);
  wire [BC_CNT_W-1:0] bc_need = (i_bc_count == '0) ? 15'h0001 : i_bc_count;
  wire bc_raw = i_bc_en && in_run && i_bus_valid && i_bus_addr == i_bc_addr;
  wire bc_reach = bc_raw && !bc_dly_ff && bc_cnt_ff == bc_need - 15'h0001;
  wire bc_evt = (bc_reach && i_bc_delay == '0) ||
      (bc_dly_ff && i_bus_valid && bc_dcnt_ff == i_bc_delay - 15'h0001);
  wire chan_brk = i_seq_mode ? (seq_armed_ff && c1_evt) : (c1_evt || c2_evt);
  // Software hits: reset point, ordered pass points, then the table
  wire sw_hit = in_run && i_swbrk_hit;
  wire rp_hit = sw_hit && i_rp_en && i_pc == i_rp_addr;
  wire pp_hit = sw_hit && !rp_hit && pp_stage_ff < i_pp_num &&
      i_pc == pp_mem[pp_stage_ff];
  wire pp_done = pp_hit && pp_stage_ff + 3'h1 == i_pp_num;
  // Slot 255 does not exist; reading it would turn the hit unknown
  wire sb_hit = sw_hit && !rp_hit && !pp_hit && i_swbrk_idx != 8'hff &&
      sb_vld_ff[i_swbrk_idx];
  wire sb_pass = sb_hit && sb_cnt_mem[i_swbrk_idx] + 16'h0001 < sb_pass_mem[i_swbrk_idx];
  wire sw_brk = pp_done || (sb_hit && !sb_pass);
  wire sw_step = rp_hit || (pp_hit && !pp_done) || sb_pass;
  wire brk_now = in_run && (i_force_break || bc_evt || chan_brk || sw_brk);
  wire cap_en = in_run && !halt_ff && !por_blk_ff;
  wire bt_rise = bt_s[5] && !bt_clk_d_ff;
  wire bt_end = bt_frm_d_ff && !bt_s[4];
  wire [31:0] bt_m = bt_mask(bt_nib_ff);
  wire [31:0] bt_merge = (bt_ref_ff & ~bt_m) | (bt_acc_ff & bt_m);

  // Next state of the run sequencer
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      EBT_ST_IDLE: if (run_rise && !seq_bad) nxt_st = EBT_ST_SWAP;
      EBT_ST_SWAP: if (walk_ff == SB_LAST) nxt_st = EBT_ST_RUN;
      EBT_ST_RUN: if (!i_run) nxt_st = EBT_ST_RESTORE;
      EBT_ST_RESTORE: if (walk_ff == SB_LAST) nxt_st = EBT_ST_IDLE;
      default: nxt_st = EBT_ST_IDLE;
    endcase
  end

  // Run control, error report and halt
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st_ff <= EBT_ST_IDLE;
      run_d_ff <= 1'b0;
      halt_ff <= 1'b0;
      err_ff <= 1'b0;
      err_code_ff <= ERR_NONE;
      running_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      running_ff <= nxt_st == EBT_ST_RUN;
      run_d_ff <= i_run;
      // Refused start keeps the target stopped
      if (st_ff == EBT_ST_IDLE && run_rise)
      begin
        err_ff <= seq_bad;
        err_code_ff <= seq_bad ? ERR_SEQ_UNSET : ERR_NONE;
      end
      if (st_ff == EBT_ST_SWAP)
        halt_ff <= 1'b0;
      else if (brk_now)
        halt_ff <= 1'b1;
    end
  end

  // Breakpoint table walk: swap on start, restore on stop
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      walk_ff <= '0;
      sw_req_ff <= 1'b0;
      sw_restore_ff <= 1'b0;
      sw_addr_ff <= '0;
    end
    else
    begin
      sw_req_ff <= 1'b0;
      if (st_ff == EBT_ST_SWAP || st_ff == EBT_ST_RESTORE)
      begin
        sw_req_ff <= sb_vld_ff[walk_ff];
        sw_restore_ff <= st_ff == EBT_ST_RESTORE;
        sw_addr_ff <= sb_addr_mem[walk_ff];
        walk_ff <= (walk_ff == SB_LAST) ? '0 : walk_ff + 8'h01;
      end
    end
  end

  // Breakpoint table contents; pass counts clear during the swap walk
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      sb_vld_ff <= '0;
    else if (i_sb_wr && i_sb_idx != 8'hff)
      sb_vld_ff[i_sb_idx] <= i_sb_valid;
    if (i_sb_wr && i_sb_idx != 8'hff)
    begin
      sb_addr_mem[i_sb_idx] <= i_sb_addr;
      sb_pass_mem[i_sb_idx] <= i_sb_pass;
    end
    if (st_ff == EBT_ST_SWAP)
      sb_cnt_mem[walk_ff] <= '0;
    else if (sb_pass)
      sb_cnt_mem[i_swbrk_idx] <= sb_cnt_mem[i_swbrk_idx] + 16'h0001;
    if (i_pp_wr && i_pp_idx != 3'h7)
      pp_mem[i_pp_idx] <= i_pp_addr;
  end

  // Pass point progress and single-step requests
  always_ff @(posedge i_clk)
  begin
    if (i_srst || st_ff == EBT_ST_SWAP)
    begin
      pp_stage_ff <= '0;
      step_ff <= 1'b0;
      c2_lost_ff <= 1'b0;
    end
    else
    begin
      step_ff <= sw_step;
      if (sw_step)
        c2_lost_ff <= 1'b1;
      if (rp_hit || pp_done)
        pp_stage_ff <= '0;
      else if (pp_hit)
        pp_stage_ff <= pp_stage_ff + 3'h1;
    end
  end

  // Comparator channels, sequence arming and bus channel counters
  always_ff @(posedge i_clk)
  begin
    if (i_srst || st_ff == EBT_ST_SWAP)
    begin
      c1_cnt_ff <= '0;
      c1_pend_ff <= 1'b0;
      c2_pend_ff <= 1'b0;
      seq_armed_ff <= 1'b0;
      bc_cnt_ff <= '0;
      bc_dly_ff <= 1'b0;
      bc_dcnt_ff <= '0;
    end
    else
    begin
      if (c1_fire)
        c1_cnt_ff <= '0;
      else if (c1_raw)
        c1_cnt_ff <= c1_cnt_ff + 12'h001;
      // Post-execution matches wait for the instruction to finish
      if (c1_post)
        c1_pend_ff <= 1'b1;
      else if (i_exec_done)
        c1_pend_ff <= 1'b0;
      if (c2_post)
        c2_pend_ff <= 1'b1;
      else if (i_exec_done)
        c2_pend_ff <= 1'b0;
      if (chan_brk)
        seq_armed_ff <= 1'b0;
      else if (c2_evt && i_seq_mode)
        seq_armed_ff <= 1'b1;
      if (bc_reach)
        bc_cnt_ff <= '0;
      else if (bc_raw && !bc_dly_ff)
        bc_cnt_ff <= bc_cnt_ff + 15'h0001;
      if (bc_evt)
        bc_dly_ff <= 1'b0;
      else if (bc_reach)
        bc_dly_ff <= 1'b1;
      if (!bc_dly_ff)
        bc_dcnt_ff <= '0;
      else if (i_bus_valid)
        bc_dcnt_ff <= bc_dcnt_ff + 15'h0001;
    end
  end

  // Trace capture; power-on reset of the target blocks it until rerun
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      tr_wp_ff <= '0;
      tr_cnt_ff <= '0;
      ts_ff <= '0;
      por_blk_ff <= 1'b0;
      por_d_ff <= 1'b1;
    end
    else
    begin
      ts_ff <= ts_ff + 32'h00000001;
      por_d_ff <= por_s;
      if (st_ff == EBT_ST_SWAP)
        por_blk_ff <= 1'b0;
      else if (in_run && por_d_ff && !por_s)
        por_blk_ff <= 1'b1;
      if (cap_en && i_bus_valid)
      begin
        tr_wp_ff <= (tr_wp_ff == TR_LAST) ? '0 : tr_wp_ff + 17'h00001;
        if (tr_cnt_ff != TR_FULL)
          tr_cnt_ff <= tr_cnt_ff + 17'h00001;
      end
    end
  end

  // Trace store write and registered read port
  always_ff @(posedge i_clk)
  begin
    if (cap_en && i_bus_valid)
      tr_mem[tr_wp_ff] <= {i_bus_addr, i_bus_data, i_bus_probe, ts_ff, i_bus_ctrl,
          i_bus_clks};
    tr_rd_ff <= tr_mem[i_tr_rd_idx];
  end

  // Branch trace port: low nibble first, frame end rebuilds the address
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      bt_clk_d_ff <= 1'b0;
      bt_frm_d_ff <= 1'b0;
      bt_acc_ff <= '0;
      bt_nib_ff <= '0;
      bt_ref_ff <= '0;
      bt_ref_ok_ff <= 1'b0;
      bt_stb_ff <= 1'b0;
      bt_addr_ff <= '0;
      bt_part_ff <= 1'b0;
    end
    else
    begin
      bt_clk_d_ff <= bt_s[5];
      bt_frm_d_ff <= bt_s[4];
      bt_stb_ff <= 1'b0;
      if (bt_end)
      begin
        bt_nib_ff <= '0;
        bt_acc_ff <= '0;
        bt_stb_ff <= cap_en;
        // Without a full reference only the difference is kept
        bt_addr_ff <= bt_ref_ok_ff ? bt_merge : (bt_acc_ff & bt_m);
        bt_part_ff <= !bt_ref_ok_ff && bt_nib_ff != BT_NIB_FULL;
        if (bt_nib_ff == BT_NIB_FULL || bt_ref_ok_ff)
        begin
          bt_ref_ff <= bt_merge;
          bt_ref_ok_ff <= 1'b1;
        end
      end
      else if (bt_rise && bt_s[4] && bt_nib_ff != BT_NIB_FULL)
      begin
        bt_acc_ff[bt_nib_ff[2:0]*4 +: 4] <= bt_s[3:0];
        bt_nib_ff <= bt_nib_ff + 4'h1;
      end
    end
  end

  assign o_running = running_ff;
  assign o_halt_req = halt_ff;
  assign o_step = step_ff;
  assign o_err = err_ff;
  assign o_err_code = err_code_ff;
  assign o_sw_req = sw_req_ff;
  assign o_sw_restore = sw_restore_ff;
  assign o_sw_addr = sw_addr_ff;
  assign o_c2_lost = c2_lost_ff;
  assign o_tr_rd_data = tr_rd_ff;
  assign o_tr_count = tr_cnt_ff;
  assign o_bt_stb = bt_stb_ff;
  assign o_bt_addr = bt_addr_ff;
  assign o_bt_partial = bt_part_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_c2_then_c1;
    seq_armed_ff ##0 c1_evt;
  endsequence
  sequence s_short_frame;
    bt_end && bt_ref_ok_ff && bt_nib_ff == 4'h4;
  endsequence

  halt_cause_a: assert property ($rose(halt_ff) |-> $past(brk_now))
    else $error("halt rose without a break source");
  force_halt_a: assert property (in_run && i_force_break |=> halt_ff)
    else $error("forced break did not halt");
  seq_refuse_a: assert property (st_ff == EBT_ST_IDLE && run_rise && seq_bad
      |=> err_ff && err_code_ff == ERR_SEQ_UNSET ##1 st_ff == EBT_ST_IDLE)
    else $error("sequence start not refused");
  seq_order_a: assert property (i_seq_mode && chan_brk |-> s_c2_then_c1)
    else $error("sequence break out of order");
  // Only meaningful while no other source is halting the target
  post_exec_a: assert property (c1_post && !i_exec_done && !halt_ff && !brk_now
      |=> c1_pend_ff && !halt_ff)
    else $error("post-execution break taken early");
  pre_exec_a: assert property (c1_fire && i_c1_sel == EBT_SEL_PC && i_c1_pre
      && !i_seq_mode |=> halt_ff)
    else $error("pre-execution break missing");
  bc_delay_a: assert property (bc_reach && i_bc_delay != '0 |-> !bc_evt ##1 bc_dly_ff)
    else $error("delay phase skipped");
  freeze_a: assert property (halt_ff |=> $stable(tr_wp_ff))
    else $error("trace captured while halted");
  por_stop_a: assert property (in_run && por_d_ff && !por_s
      |=> !cap_en [*2])
    else $error("trace continued after power-on reset");
  bt_keep_a: assert property (s_short_frame
      |=> bt_addr_ff[31:16] == $past(bt_ref_ff[31:16]))
    else $error("upper address bits not kept");
  step_lose_a: assert property (sw_step |=> step_ff && c2_lost_ff)
    else $error("pass step did not take second channel");
endmodule : ebt_top

// ===== hdl/ebt_pkg.sv
// Shared constants and types of the emulator break and trace unit
package ebt_pkg;
  // Occurrence counter widths: 4095 and 32767 at most
  localparam int unsigned C1_CNT_W = 12;
  localparam int unsigned BC_CNT_W = 15;
  // Software breakpoint table and pass counts up to 65535
  localparam int unsigned SB_NUM = 255;
  localparam int unsigned SB_IDX_W = 8;
  localparam int unsigned SB_PASS_W = 16;
  // Ordered pass points
  localparam int unsigned PP_NUM = 7;
  localparam int unsigned PP_IDX_W = 3;
  // Trace store: depth, pointer width, record width
  localparam int unsigned TR_DEPTH = 131070;
  localparam int unsigned TR_AW = 17;
  localparam int unsigned TR_REC_W = 119;
  localparam logic [TR_AW-1:0] TR_LAST = 17'h1fffd;
  localparam logic [TR_AW-1:0] TR_FULL = 17'h1fffe;
  // Branch trace port nibble transfer
  localparam int unsigned BT_NIB_W = 4;
  localparam logic [3:0] BT_NIB_FULL = 4'h8;
  // Error codes reported at run start
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_SEQ_UNSET = 8'h23;
  // Last breakpoint walk index
  localparam logic [SB_IDX_W-1:0] SB_LAST = 8'hfe;
  // Comparator field selection
  typedef enum logic [2:0] {
    EBT_SEL_ADDR = 3'h0,
    EBT_SEL_DATA = 3'h1,
    EBT_SEL_PC = 3'h2,
    EBT_SEL_ASID = 3'h3,
    EBT_SEL_RW = 3'h4,
    EBT_SEL_TYPE = 3'h5
  } ebt_sel_e;
  // Run sequencing, Gray coded along idle-swap-run-restore
  typedef enum logic [1:0] {
    EBT_ST_IDLE = 2'h0,
    EBT_ST_SWAP = 2'h1,
    EBT_ST_RUN = 2'h3,
    EBT_ST_RESTORE = 2'h2
  } ebt_state_e;
endpackage : ebt_pkg

// ===== hdl/ebt_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ebt_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_ff; // Metastability catcher, read only by s2
  logic [W-1:0] s2_ff; // Second stage
  logic [W-1:0] s3_ff; // Third stage
  logic [W-1:0] q_ff; // Filtered output

  // Shift chain
  always_ff @(posedge i_clk)
  begin
    s1_ff <= i_d;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  // A bit changes only once stages two and three agree
  for (genvar b = 0; b < W; b++)
  begin : g_bit
    always_ff @(posedge i_clk)
    begin
      if (i_srst)
        q_ff[b] <= 1'b0;
      else if (s2_ff[b] == s3_ff[b])
        q_ff[b] <= s3_ff[b];
    end
  end

  assign o_q = q_ff;
endmodule : ebt_sync

// ===== sim/ebt_link_model.sv
// Branch trace link driver standing in for the target's on-chip debug port
`timescale 1ns/1ps
module ebt_link_model (
  output logic o_bt_clk,
  output logic o_bt_frame,
  output logic [3:0] o_bt_data
);
  // Link clock stands still low outside frames
  initial
  begin
    o_bt_clk = 1'b0;
    o_bt_frame = 1'b0;
    o_bt_data = 4'h0;
  end
  // Sends n nibbles low first; 160 ns period, slower than the target clock
  task send(input int n, input logic [31:0] v);
    for (int k = 0; k < n; k++)
    begin
      o_bt_frame = 1'b1;
      o_bt_data = v[4*k +: 4];
      #80 o_bt_clk = 1'b1;
      #80 o_bt_clk = 1'b0;
    end
    o_bt_frame = 1'b0;
    // Released data is inverted so a stale nibble cannot pass for a valid one
    o_bt_data = ~o_bt_data;
  endtask : send
endmodule : ebt_link_model

// ===== sim/ebt_top_bench.sv
// Self-checking bench of the break and trace unit
`timescale 1ns/1ps
module ebt_top_bench;
  import ebt_pkg::*;
  logic i_clk, i_srst, i_run, i_force_break, i_bus_valid, i_bus_rw, i_pc_valid, i_exec_done;
  logic [31:0] i_bus_addr, i_bus_data, i_pc, i_c1_value, i_c2_value, i_bc_addr, i_sb_addr;
  logic [31:0] i_pp_addr, i_rp_addr, o_sw_addr, o_bt_addr;
  logic [7:0] i_bus_asid, i_bus_clks, i_sb_idx, i_swbrk_idx, o_err_code;
  logic [1:0] i_bus_type;
  logic [3:0] i_bus_probe, i_bt_data;
  logic [10:0] i_bus_ctrl;
  logic i_c1_en, i_c1_pre, i_c2_en, i_c2_pre, i_bc_en, i_seq_mode, i_sb_wr, i_sb_valid;
  ebt_sel_e i_c1_sel, i_c2_sel;
  logic [C1_CNT_W-1:0] i_c1_count;
  logic [BC_CNT_W-1:0] i_bc_count, i_bc_delay;
  logic [SB_PASS_W-1:0] i_sb_pass;
  logic i_pp_wr, i_rp_en, i_swbrk_hit, i_bt_clk, i_bt_frame, i_por_n;
  logic [PP_IDX_W-1:0] i_pp_idx, i_pp_num;
  logic [TR_AW-1:0] i_tr_rd_idx, o_tr_count;
  logic o_running, o_halt_req, o_step, o_err, o_sw_req, o_sw_restore, o_c2_lost;
  logic o_bt_stb, o_bt_partial;
  logic [TR_REC_W-1:0] o_tr_rd_data;
  int err_total = 0;
  int compares = 0;
  int n;
  logic stp; // Step pulse seen at the last break instruction
  ebt_top DUT (.*);
  ebt_link_model LINK (.o_bt_clk(i_bt_clk), .o_bt_frame(i_bt_frame), .o_bt_data(i_bt_data));
  // 100 MHz clock
  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;
  // Inputs change 1 ns after the edge so no race with the design's sampling
  task tick(input int k = 1);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : tick
  // Compares one value and counts it
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One external bus cycle at address a
  task bus(input logic [31:0] a);
    i_bus_valid = 1'b1;
    i_bus_addr = a;
    tick();
    i_bus_valid = 1'b0;
    tick(2);
  endtask : bus
  // Starts a run, counting swap requests during the walk
  task start();
    i_run = 1'b1;
    n = 0;
    for (int k = 0; k < 600 && o_running !== 1'b1; k++)
    begin
      tick();
      n += (o_sw_req === 1'b1);
      if (o_sw_req === 1'b1)
      begin
        chk("swap addr", o_sw_addr, 32'h0000_0200);
        chk("swap dir", o_sw_restore, 0);
      end
    end
    chk("running", o_running, 1);
  endtask : start
  // Stops a run and lets the restore walk finish
  task stop();
    i_run = 1'b0;
    for (int k = 0; k < 300; k++)
    begin
      tick();
      if (o_sw_req === 1'b1)
      begin
        chk("restore addr", o_sw_addr, 32'h0000_0200);
        chk("restore dir", o_sw_restore, 1);
      end
    end
    chk("idle", o_running, 0);
  endtask : stop
  // Waits a bounded time for a branch address strobe
  task btchk(input logic [31:0] exp);
    for (int k = 0; k < 40 && o_bt_stb !== 1'b1; k++) tick();
    chk("bt_stb", o_bt_stb, 1);
    chk("bt_addr", o_bt_addr, exp);
    chk("bt_partial", o_bt_partial, 0);
  endtask : btchk
  // One break instruction executed at pc from slot idx; keeps the step pulse
  task swhit(input logic [31:0] pc, input logic [7:0] idx);
    i_pc = pc;
    i_swbrk_idx = idx;
    i_swbrk_hit = 1'b1;
    tick();
    i_swbrk_hit = 1'b0;
    stp = o_step;
    tick();
  endtask : swhit
  // Prints counts and the verdict, then ends the run
  task summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Watchdog: the tests need well under 20000 cycles
  initial
  begin
    #400000;
    err_total++;
    summarize();
  end
  // Test sequence
  initial
  begin
    {i_run, i_force_break, i_bus_valid, i_bus_rw, i_pc_valid, i_exec_done} = '0;
    {i_bus_addr, i_bus_data, i_pc, i_bc_addr, i_pp_addr, i_rp_addr} = '0;
    {i_bus_asid, i_bus_clks, i_swbrk_idx, i_bus_type, i_bus_probe, i_bus_ctrl} = '0;
    {i_c1_pre, i_c2_pre, i_bc_en, i_bc_count, i_bc_delay, i_sb_pass, i_sb_wr} = '0;
    {i_pp_wr, i_rp_en, i_swbrk_hit, i_pp_idx, i_pp_num, i_tr_rd_idx} = '0;
    i_c1_sel = EBT_SEL_ADDR;
    i_c2_sel = EBT_SEL_ADDR;
    i_c1_value = 32'h0000_0100;
    i_c2_value = 32'h0000_0300;
    i_c1_count = 12'h003;
    i_sb_idx = 8'h00;
    i_sb_valid = 1'b1;
    // Breakpoint sits on a plain instruction, never in a delay slot
    i_sb_addr = 32'h0000_0200;
    i_por_n = 1'b1;
    i_c1_en = 1'b1;
    i_c2_en = 1'b0;
    i_seq_mode = 1'b1;
    i_srst = 1'b1;
    tick(3);
    i_srst = 1'b0;
    tick(5);
    // Refused start: sequence with second channel unset
    i_run = 1'b1;
    tick(3);
    chk("err", o_err, 1);
    chk("err_code", o_err_code, 8'h23);
    chk("running", o_running, 0);
    i_run = 1'b0;
    $display("test refused start done");
    // Counted first channel, one breakpoint swapped in
    i_seq_mode = 1'b0;
    i_sb_wr = 1'b1;
    tick();
    i_sb_wr = 1'b0;
    tick();
    start();
    chk("swaps", n, 1);
    bus(32'h0000_0100);
    bus(32'h0000_0100);
    chk("halt early", o_halt_req, 0);
    bus(32'h0000_0100);
    chk("halt", o_halt_req, 1);
    bus(32'h0000_0100);
    chk("trace count", o_tr_count, 3);
    i_tr_rd_idx = '0;
    tick(2);
    chk("rec addr", o_tr_rd_data[118:87], 32'h0000_0100);
    stop();
    $display("test counted break done");
    // Sequence mode: first channel alone does not break, second then first does
    i_seq_mode = 1'b1;
    i_c2_en = 1'b1;
    i_c1_count = 12'h001;
    start();
    bus(32'h0000_0100);
    chk("seq early", o_halt_req, 0);
    bus(32'h0000_0300);
    chk("seq armed", o_halt_req, 0);
    bus(32'h0000_0100);
    chk("seq halt", o_halt_req, 1);
    stop();
    $display("test sequence done");
    // Independent channels, and the branch trace link while running
    i_seq_mode = 1'b0;
    start();
    LINK.send(8, 32'h1234_5678);
    btchk(32'h1234_5678);
    tick();
    LINK.send(4, 32'h0000_abcd);
    btchk(32'h1234_abcd);
    bus(32'h0000_0300);
    chk("c2 halt", o_halt_req, 1);
    stop();
    $display("test independent and link done");
    // Bus channel count then delay; a target power-on reset stops the trace
    i_bc_en = 1'b1;
    i_bc_addr = 32'h0000_0400;
    i_bc_count = 15'h0002;
    i_bc_delay = 15'h0002;
    start();
    i_por_n = 1'b0;
    tick(6);
    bus(32'h0000_0400);
    chk("por trace", o_tr_count, 7);
    bus(32'h0000_0400);
    bus(32'h0000_0500);
    chk("delay early", o_halt_req, 0);
    bus(32'h0000_0500);
    chk("delay halt", o_halt_req, 1);
    i_por_n = 1'b1;
    i_bc_en = 1'b0;
    stop();
    $display("test bus channel and power-on reset done");
    // PC match after execution waits for completion; before execution breaks at once
    i_c1_sel = EBT_SEL_PC;
    i_pc = 32'h0000_0100;
    start();
    i_pc_valid = 1'b1;
    tick();
    i_pc_valid = 1'b0;
    tick(2);
    chk("post early", o_halt_req, 0);
    i_exec_done = 1'b1;
    tick();
    i_exec_done = 1'b0;
    tick();
    chk("post halt", o_halt_req, 1);
    stop();
    i_c1_pre = 1'b1;
    start();
    i_pc_valid = 1'b1;
    tick();
    i_pc_valid = 1'b0;
    chk("pre halt", o_halt_req, 1);
    stop();
    $display("test pc breaks done");
    // Counted software breakpoint steps on the second channel, then breaks
    i_sb_idx = 8'h01;
    i_sb_pass = 16'h0002;
    i_sb_wr = 1'b1;
    tick();
    i_sb_wr = 1'b0;
    start();
    chk("swaps", n, 2);
    swhit(32'h0000_0200, 8'h01);
    chk("pass step", stp, 1);
    chk("c2 lost", o_c2_lost, 1);
    chk("pass early", o_halt_req, 0);
    swhit(32'h0000_0200, 8'h01);
    chk("pass halt", o_halt_req, 1);
    stop();
    // Two ordered pass points; the reset point restarts the order
    i_pp_num = 3'h2;
    i_rp_en = 1'b1;
    i_rp_addr = 32'h0000_0030;
    i_pp_wr = 1'b1;
    i_pp_addr = 32'h0000_0010;
    tick();
    i_pp_idx = 3'h1;
    i_pp_addr = 32'h0000_0020;
    tick();
    i_pp_wr = 1'b0;
    start();
    swhit(32'h0000_0010, 8'h02);
    chk("pp step", stp, 1);
    swhit(32'h0000_0030, 8'h02);
    swhit(32'h0000_0020, 8'h02);
    chk("pp reset", o_halt_req, 0);
    swhit(32'h0000_0010, 8'h02);
    swhit(32'h0000_0020, 8'h02);
    chk("pp halt", o_halt_req, 1);
    stop();
    $display("test software breaks done");
    // Forced break halts at once
    start();
    i_force_break = 1'b1;
    tick();
    i_force_break = 1'b0;
    chk("forced halt", o_halt_req, 1);
    stop();
    $display("test forced break done");
    summarize();
  end
endmodule : ebt_top_bench
